// >>> rtl/gpmx_pkg.sv
// constants and types shared by the pin mode and port-1 data block
// assumes an APB master, one clock, pad cells outside the block
`default_nettype none

package gpmx_pkg;

  ////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_PINS  = 16;
  localparam int PORT_W    = 8;
  localparam int NUM_FUNC  = 26;
  localparam int FSEL_W    = 5;
  localparam int PD_W      = 2;
  localparam int ADC_PINS  = 4;
  localparam int DIAG_PINS = 8;

  ////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [31:0] OFF_PIN0_6_MODE      = 32'h50003012;
  localparam logic [31:0] OFF_PIN0_7_MODE      = 32'h50003014;
  localparam logic [31:0] OFF_PORT1_OUTPUT_DATA = 32'h50003020;
  localparam logic [31:0] OFF_PORT1_BIT_SET    = 32'h50003022;
  localparam logic [31:0] OFF_PORT1_BIT_CLEAR  = 32'h50003024;
  localparam logic [31:0] OFF_PIN1_0_MODE      = 32'h50003026;
  localparam logic [31:0] OFF_PIN1_1_MODE      = 32'h50003028;
  localparam logic [31:0] OFF_PIN1_4_MODE      = 32'h5000302E;
  localparam logic [31:0] OFF_PIN1_5_MODE      = 32'h50003030;
  localparam logic [31:0] PORT0_MODE_BASE      = 32'h50003006;
  localparam logic [31:0] PORT1_MODE_BASE      = OFF_PIN1_0_MODE;
  localparam logic [31:0] MODE_STEP            = 32'h00000002;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FSEL_LSB = 0;
  localparam int PD_LSB   = 8;
  localparam int DATA_LSB = 0;

  ////////////////////////////////////////////////////////////////////////
  // function codes and pull/direction codes
  localparam logic [4:0] FUNC_GPIO = 5'h00;
  localparam logic [4:0] FUNC_ADC  = 5'h0F;
  localparam logic [4:0] FUNC_DIAG = 5'h12;
  localparam logic [4:0] FUNC_LAST = 5'h19;
  localparam logic [1:0] PD_FLOAT     = 2'h0;
  localparam logic [1:0] PD_PULL_UP   = 2'h1;
  localparam logic [1:0] PD_PULL_DOWN = 2'h2;
  localparam logic [1:0] PD_OUTPUT    = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [4:0] MODE_FSEL_RST   = 5'h00;
  localparam logic [1:0] MODE_PD_RST     = 2'h2;
  localparam logic [1:0] MODE_PD_RST_UP  = 2'h1;
  localparam int         PULLUP_PIN_A    = 12;
  localparam int         PULLUP_PIN_B    = 13;
  localparam logic [7:0] PORT1_DATA_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // bus phase tracker
  typedef enum logic [1:0] {
    GPMX_ST_IDLE   = 2'b01,
    GPMX_ST_ACCESS = 2'b10
  } gpmx_apb_st_t;

endpackage

`default_nettype wire

// >>> rtl/gpmx_pin_cell.sv
// per-pin function decode: pad drive, pulls and analog enable
// assumes peripherals present output value and enable per function code
`timescale 1ns/1ps
`default_nettype none

module gpmx_pin_cell #(
  parameter bit HAS_ADC  = 1'b0,
  parameter bit HAS_DIAG = 1'b0
) (
  // mode fields
  input  wire logic [4:0]                    fsel,
  input  wire logic [1:0]                    pull_dir,
  // data sources
  input  wire logic                          gpio_out,
  input  wire logic [gpmx_pkg::NUM_FUNC-1:0] func_out,
  input  wire logic [gpmx_pkg::NUM_FUNC-1:0] func_oe,
  // pad controls
  output logic                               pad_out,
  output logic                               pad_oe,
  output logic                               pull_up,
  output logic                               pull_down,
  output logic                               analog,
  output logic                               routed
);

  wire       is_gpio  = (fsel == gpmx_pkg::FUNC_GPIO);
  wire       in_range = (fsel <= gpmx_pkg::FUNC_LAST) && !is_gpio;
  wire       adc_bad  = (fsel == gpmx_pkg::FUNC_ADC) && !HAS_ADC;
  wire       diag_bad = (fsel == gpmx_pkg::FUNC_DIAG) && !HAS_DIAG;
  wire       code_ok  = in_range && !adc_bad && !diag_bad;
  wire       periph   = code_ok && (fsel != gpmx_pkg::FUNC_ADC);
  // out-of-range codes index bit 0, which is never used
  wire [4:0] sel_idx  = periph ? fsel : gpmx_pkg::FUNC_GPIO;
  wire       gpio_drv = is_gpio && (pull_dir == gpmx_pkg::PD_OUTPUT);

  assign analog    = code_ok && (fsel == gpmx_pkg::FUNC_ADC);
  assign routed    = periph;
  assign pad_oe    = gpio_drv || (periph && func_oe[sel_idx]);
  assign pad_out   = is_gpio ? gpio_out : (periph && func_out[sel_idx]);
  // analog pins drop the field entirely
  assign pull_up   = !analog && (pull_dir == gpmx_pkg::PD_PULL_UP);
  assign pull_down = !analog && (pull_dir == gpmx_pkg::PD_PULL_DOWN);

endmodule

`default_nettype wire

// >>> rtl/gpmx_in_select.sv
// resolves which pin feeds each peripheral input function
// assumes pins are numbered port-0 first, low index first
`timescale 1ns/1ps
`default_nettype none

module gpmx_in_select #(
  parameter int NUM_PINS = gpmx_pkg::NUM_PINS,
  parameter int NUM_FUNC = gpmx_pkg::NUM_FUNC
) (
  // per-pin selection
  input  wire logic [NUM_PINS*5-1:0] pin_fsel,
  input  wire logic [NUM_PINS-1:0]   pin_routed,
  input  wire logic [NUM_PINS-1:0]   pad_in,
  // level seen by a function with no pin
  input  wire logic [NUM_FUNC-1:0]   idle_level,
  output logic      [NUM_FUNC-1:0]   func_in
);

  genvar f;
  for (f = 0; f < NUM_FUNC; f++) begin : g_func
    logic sel_v;
    // walking downward lets the lowest matching pin win
    always_comb begin
      sel_v = idle_level[f];
      for (int p = NUM_PINS - 1; p >= 0; p--) begin
        if (pin_routed[p] && (pin_fsel[p*5 +: 5] == 5'(f))) begin
          sel_v = pad_in[p];
        end
      end
    end
    assign func_in[f] = sel_v;
  end

endmodule

`default_nettype wire

// >>> rtl/gpmx_top.sv
// pin mode registers, port-1 output latch and APB slave
// assumes pads resolve drive, pulls and analog from the enables;
// port-0 output values come from outside this block
`timescale 1ns/1ps
`default_nettype none

module gpmx_top #(
  parameter logic [gpmx_pkg::NUM_FUNC-1:0] FUNC_IDLE = 26'h3FFFFFF
) (
  // clock and reset
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [31:0]                   PADDR,
  input  wire logic [31:0]                   PWDATA,
  input  wire logic [3:0]                    PSTRB,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // pads, index 0..7 port 0, 8..15 port 1
  input  wire logic [gpmx_pkg::NUM_PINS-1:0] PAD_IN,
  output logic      [gpmx_pkg::NUM_PINS-1:0] PAD_OUT,
  output logic      [gpmx_pkg::NUM_PINS-1:0] PAD_OE,
  output logic      [gpmx_pkg::NUM_PINS-1:0] PAD_PULLUP_EN,
  output logic      [gpmx_pkg::NUM_PINS-1:0] PAD_PULLDOWN_EN,
  output logic      [gpmx_pkg::NUM_PINS-1:0] PAD_ANALOG_EN,
  // port data
  input  wire logic [gpmx_pkg::PORT_W-1:0]   PORT0_LATCH,
  output logic      [gpmx_pkg::PORT_W-1:0]   PORT1_LATCH,
  // peripheral signals, indexed by function code
  input  wire logic [gpmx_pkg::NUM_FUNC-1:0] FUNC_OUT,
  input  wire logic [gpmx_pkg::NUM_FUNC-1:0] FUNC_OE,
  output logic      [gpmx_pkg::NUM_FUNC-1:0] FUNC_IN
);

  localparam int NP = gpmx_pkg::NUM_PINS;
  localparam int PW = gpmx_pkg::PORT_W;
  localparam int NF = gpmx_pkg::NUM_FUNC;

  // pad reset images; must equal the decode of the mode reset codes
  localparam logic [NP-1:0] PIN_A_BIT = NP'(1) << gpmx_pkg::PULLUP_PIN_A;
  localparam logic [NP-1:0] PIN_B_BIT = NP'(1) << gpmx_pkg::PULLUP_PIN_B;
  localparam logic [NP-1:0] PU_RST    = PIN_A_BIT | PIN_B_BIT;
  localparam logic [NP-1:0] PD_RST_V  = ~PU_RST;

  ////////////////////////////////////////////////////////////////////////
  // bus phase

  gpmx_pkg::gpmx_apb_st_t st_r;
  gpmx_pkg::gpmx_apb_st_t st_nxt;

  wire setup_ph  = PSEL && !PENABLE;
  wire access_ph = PSEL && PENABLE && (st_r == gpmx_pkg::GPMX_ST_ACCESS);
  wire wr_en     = access_ph && PWRITE;

  always_comb begin
    case (st_r)
      gpmx_pkg::GPMX_ST_IDLE: begin
        st_nxt = setup_ph ? gpmx_pkg::GPMX_ST_ACCESS
                          : gpmx_pkg::GPMX_ST_IDLE;
      end
      gpmx_pkg::GPMX_ST_ACCESS: begin
        // zero wait states: access always ends here
        st_nxt = setup_ph ? gpmx_pkg::GPMX_ST_ACCESS
                          : gpmx_pkg::GPMX_ST_IDLE;
      end
      default: begin
        st_nxt = gpmx_pkg::GPMX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_r <= gpmx_pkg::GPMX_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  wire addr_ok = (PADDR[1:0] == 2'h0);
  wire hit_data;
  wire hit_set;
  wire hit_clr;
  wire [NP-1:0] hit_mode;

  assign hit_data = addr_ok &&
    (PADDR[31:2] == gpmx_pkg::OFF_PORT1_OUTPUT_DATA[29:0]);
  assign hit_set = addr_ok &&
    (PADDR[31:2] == gpmx_pkg::OFF_PORT1_BIT_SET[29:0]);
  assign hit_clr = addr_ok &&
    (PADDR[31:2] == gpmx_pkg::OFF_PORT1_BIT_CLEAR[29:0]);

  genvar g;
  for (g = 0; g < NP; g++) begin : g_dec
    localparam logic [31:0] BASE = (g < PW) ? gpmx_pkg::PORT0_MODE_BASE
                                            : gpmx_pkg::PORT1_MODE_BASE;
    localparam logic [31:0] SLOT = 32'((g < PW) ? g : g - PW);
    localparam logic [31:0] IDX  = 32'(BASE + gpmx_pkg::MODE_STEP * SLOT);
    assign hit_mode[g] = addr_ok && (PADDR[31:2] == IDX[29:0]);
  end

  wire any_hit = hit_data || hit_set || hit_clr || (|hit_mode);

  ////////////////////////////////////////////////////////////////////////
  // byte lanes; only the low two lanes carry fields

  wire lane0 = PSTRB[0];
  wire lane1 = PSTRB[1];
  wire [PW-1:0] wd_byte = PWDATA[gpmx_pkg::DATA_LSB +: PW];
  wire [4:0]    wd_fsel = PWDATA[gpmx_pkg::FSEL_LSB +: gpmx_pkg::FSEL_W];
  wire [1:0]    wd_pd   = PWDATA[gpmx_pkg::PD_LSB +: gpmx_pkg::PD_W];

  ////////////////////////////////////////////////////////////////////////
  // pin mode registers

  logic [4:0]      fsel_r [NP];
  logic [1:0]      pd_r   [NP];
  logic [NP*5-1:0] fsel_flat;

  for (g = 0; g < NP; g++) begin : g_mode
    // two port-1 pins come up pulled up, the rest pulled down
    localparam logic [1:0] PD_RST =
      ((g == gpmx_pkg::PULLUP_PIN_A) || (g == gpmx_pkg::PULLUP_PIN_B))
        ? gpmx_pkg::MODE_PD_RST_UP : gpmx_pkg::MODE_PD_RST;
    wire wr_fsel = wr_en && hit_mode[g] && lane0;
    wire wr_pd   = wr_en && hit_mode[g] && lane1;
    wire [4:0] fsel_nxt = wr_fsel ? wd_fsel : fsel_r[g];
    wire [1:0] pd_nxt   = wr_pd ? wd_pd : pd_r[g];

    always_ff @(posedge CLOCK) begin
      if (RST) begin
        fsel_r[g] <= gpmx_pkg::MODE_FSEL_RST;
        pd_r[g]   <= PD_RST;
      end else begin
        fsel_r[g] <= fsel_nxt;
        pd_r[g]   <= pd_nxt;
      end
    end

    assign fsel_flat[g*5 +: 5] = fsel_r[g];
  end

  ////////////////////////////////////////////////////////////////////////
  // port-1 output latch

  logic [PW-1:0] latch_r;
  logic [PW-1:0] latch_nxt;

  wire wr_data = wr_en && hit_data && lane0;
  wire wr_set  = wr_en && hit_set && lane0;
  wire wr_clr  = wr_en && hit_clr && lane0;

  // set and clear act only on the bits written as one
  wire [PW-1:0] latch_set = latch_r | wd_byte;
  wire [PW-1:0] latch_clr = latch_r & ~wd_byte;

  always_comb begin
    latch_nxt = latch_r;
    if (wr_data) begin
      latch_nxt = wd_byte;
    end else if (wr_set) begin
      latch_nxt = latch_set;
    end else if (wr_clr) begin
      latch_nxt = latch_clr;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      latch_r <= gpmx_pkg::PORT1_DATA_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign PORT1_LATCH = latch_r;

  ////////////////////////////////////////////////////////////////////////
  // read path; only defined fields are placed, the rest stay zero

  logic [31:0] mode_rd [NP];
  logic [31:0] mode_rd_or;

  for (g = 0; g < NP; g++) begin : g_rd
    always_comb begin
      mode_rd[g] = 32'h00000000;
      if (hit_mode[g]) begin
        mode_rd[g][gpmx_pkg::FSEL_LSB +: gpmx_pkg::FSEL_W] = fsel_r[g];
        mode_rd[g][gpmx_pkg::PD_LSB +: gpmx_pkg::PD_W]     = pd_r[g];
      end
    end
  end

  always_comb begin
    mode_rd_or = 32'h00000000;
    for (int i = 0; i < NP; i++) begin
      mode_rd_or = mode_rd_or | mode_rd[i];
    end
  end

  // data read shows the pins, not the latch
  wire [31:0] data_rd = hit_data ? {24'h000000, PAD_IN[NP-1:PW]}
                                 : 32'h00000000;
  // set and clear registers contribute nothing
  wire [31:0] rd_mux  = mode_rd_or | data_rd;

  logic [31:0] prdata_r;
  logic        perr_r;

  // writes answer zero; a miss flags an error in the access phase
  wire        rd_req = setup_ph && !PWRITE;
  wire [31:0] rd_val = rd_req ? rd_mux : 32'h00000000;
  wire        miss   = !any_hit;

  // sampled in the setup cycle, so the pin value is one cycle old
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      prdata_r <= 32'h00000000;
      perr_r   <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= rd_val;
      perr_r   <= miss;
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = (st_r == gpmx_pkg::GPMX_ST_ACCESS);
  assign PSLVERR = PREADY && perr_r;

  ////////////////////////////////////////////////////////////////////////
  // pin cells

  wire [NP-1:0] gpio_src = {latch_r, PORT0_LATCH};
  wire [NP-1:0] c_out;
  wire [NP-1:0] c_oe;
  wire [NP-1:0] c_pu;
  wire [NP-1:0] c_pd;
  wire [NP-1:0] c_an;
  wire [NP-1:0] c_routed;

  for (g = 0; g < NP; g++) begin : g_pin
    gpmx_pin_cell #(
      .HAS_ADC  (g < gpmx_pkg::ADC_PINS),
      .HAS_DIAG (g < gpmx_pkg::DIAG_PINS)
    ) u_cell (
      .fsel      (fsel_r[g]),
      .pull_dir  (pd_r[g]),
      .gpio_out  (gpio_src[g]),
      .func_out  (FUNC_OUT),
      .func_oe   (FUNC_OE),
      .pad_out   (c_out[g]),
      .pad_oe    (c_oe[g]),
      .pull_up   (c_pu[g]),
      .pull_down (c_pd[g]),
      .analog    (c_an[g]),
      .routed    (c_routed[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // input function resolution

  wire [NF-1:0] func_in_c;

  gpmx_in_select #(
    .NUM_PINS (NP),
    .NUM_FUNC (NF)
  ) u_in_sel (
    .pin_fsel   (fsel_flat),
    .pin_routed (c_routed),
    .pad_in     (PAD_IN),
    .idle_level (FUNC_IDLE),
    .func_in    (func_in_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // output flops; costs one cycle from register write to pad

  logic [NP-1:0] pad_out_r;
  logic [NP-1:0] pad_oe_r;
  logic [NP-1:0] pad_pu_r;
  logic [NP-1:0] pad_pd_r;
  logic [NP-1:0] pad_an_r;
  logic [NF-1:0] func_in_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pad_out_r <= 16'h0000;
      pad_oe_r  <= 16'h0000;
      pad_pu_r  <= PU_RST;
      pad_pd_r  <= PD_RST_V;
      pad_an_r  <= 16'h0000;
      func_in_r <= FUNC_IDLE;
    end else begin
      pad_out_r <= c_out;
      pad_oe_r  <= c_oe;
      pad_pu_r  <= c_pu;
      pad_pd_r  <= c_pd;
      pad_an_r  <= c_an;
      func_in_r <= func_in_c;
    end
  end

  assign PAD_OUT         = pad_out_r;
  assign PAD_OE          = pad_oe_r;
  assign PAD_PULLUP_EN   = pad_pu_r;
  assign PAD_PULLDOWN_EN = pad_pd_r;
  assign PAD_ANALOG_EN   = pad_an_r;
  assign FUNC_IN         = func_in_r;

endmodule

`default_nettype wire

// >>> rtl/gpmx_unused_guard.sv
// holds no module; kept empty on purpose
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> dv/gpmx_checker.sv
// assertions on the pin mode and port-1 data block
// assumes a bind to gpmx_top; byte address is four times the index
`timescale 1ns/1ps
`default_nettype none

module gpmx_checker (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  // pads and latch
  input wire logic [15:0] PAD_IN,
  input wire logic [15:0] PAD_OE,
  input wire logic [15:0] PAD_PULLUP_EN,
  input wire logic [15:0] PAD_PULLDOWN_EN,
  input wire logic [15:0] PAD_ANALOG_EN,
  input wire logic [7:0]  PORT1_LATCH
);
  localparam logic [31:0] A_DAT = 32'h4000C080;
  localparam logic [31:0] A_SET = 32'h4000C088;
  localparam logic [31:0] A_CLR = 32'h4000C090;
  wire logic wa  = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  wire logic rda = PSEL && PENABLE && PREADY && !PWRITE;
  logic [7:0] pins_r;

  // pins as seen in the setup cycle, which a data read returns
  always_ff @(posedge CLOCK) pins_r <= PAD_IN[15:8];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////
  property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_dat; wa && PADDR == A_DAT |=> PORT1_LATCH == $past(PWDATA[7:0]);
  endproperty
  a_dat: assert property (p_dat) else $error("latch not loaded");
  property p_set; wa && PADDR == A_SET |=>
    PORT1_LATCH == ($past(PORT1_LATCH) | $past(PWDATA[7:0])); endproperty
  a_set: assert property (p_set) else $error("set write wrong");
  property p_clr; wa && PADDR == A_CLR |=>
    PORT1_LATCH == ($past(PORT1_LATCH) & ~$past(PWDATA[7:0])); endproperty
  a_clr: assert property (p_clr) else $error("clear write wrong");
  property p_hold; !(PSEL && PENABLE && PWRITE) |=> $stable(PORT1_LATCH);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved alone");
  property p_rdd; rda && PADDR == A_DAT |-> PRDATA == {24'h000000, pins_r};
  endproperty
  a_rdd: assert property (p_rdd) else $error("data read not pins");
  property p_rsc; rda && (PADDR == A_SET || PADDR == A_CLR) |-> PRDATA == 0;
  endproperty
  a_rsc: assert property (p_rsc) else $error("set or clear read");
  property p_rsv; rda |-> PRDATA[31:10] == 22'h000000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ana; (PAD_ANALOG_EN & (PAD_OE | PAD_PULLUP_EN | PAD_PULLDOWN_EN))
    == 16'h0000; endproperty
  a_ana: assert property (p_ana) else $error("analog pin has pull");
  property p_anp; PAD_ANALOG_EN[15:4] == 12'h000; endproperty
  a_anp: assert property (p_anp) else $error("analog on bad pin");
  property p_rst; disable iff (1'b0) RST ##1 RST |=> PORT1_LATCH == 8'h00 &&
    PAD_PULLUP_EN == 16'h3000 && PAD_PULLDOWN_EN == 16'hCFFF; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_set: cover property (wa && PADDR == A_SET);
  c_clr: cover property (wa && PADDR == A_CLR);
  c_ana: cover property (PAD_ANALOG_EN != 16'h0000);
endmodule

bind gpmx_top gpmx_checker u_chk (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PAD_IN, .PAD_OE,
  .PAD_PULLUP_EN, .PAD_PULLDOWN_EN, .PAD_ANALOG_EN, .PORT1_LATCH);

`default_nettype wire

// >>> dv/gpmx_pad_model.sv
// pad ring and external world around the block
// assumes testbench drives ext_val/ext_en only on undriven pins
`timescale 1ns/1ps
`default_nettype none

module gpmx_pad_model (
  // clock
  input  wire logic        clk,
  // pad controls
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] pull_up,
  input  wire logic [15:0] pull_down,
  // outside drivers
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  // resolved levels
  output logic      [15:0] level
);
  logic flt_r = 1'b0;

  // floating pin changes every cycle, never a steady guess
  always_ff @(posedge clk) flt_r <= ~flt_r;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      level[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                 pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : flt_r;
    end
  end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the pin mode and port-1 data block
// assumes gpmx_top, the pad model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0]  PSTRB = 4'hF;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [15:0] PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP_EN, PAD_PULLDOWN_EN;
  logic [15:0] PAD_ANALOG_EN;
  logic [15:0] ext_val = 16'h0;
  logic [15:0] ext_en = 16'h0;
  logic [7:0]  PORT0_LATCH = 8'h00;
  logic [7:0]  PORT1_LATCH;
  logic [25:0] FUNC_OUT = 26'h0;
  logic [25:0] FUNC_OE = 26'h0;
  logic [25:0] FUNC_IN;
  int          miscompares = 0;
  int          compares = 0;
  logic [31:0] rd, d, s, c;
  logic        err;

  always #50 CLOCK = ~CLOCK;

  gpmx_top uut (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB, .PRDATA, .PREADY, .PSLVERR, .PAD_IN, .PAD_OUT, .PAD_OE,
    .PAD_PULLUP_EN, .PAD_PULLDOWN_EN, .PAD_ANALOG_EN, .PORT0_LATCH,
    .PORT1_LATCH, .FUNC_OUT, .FUNC_OE, .FUNC_IN);
  gpmx_pad_model pads (.clk(CLOCK), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
    .pull_up(PAD_PULLUP_EN), .pull_down(PAD_PULLDOWN_EN),
    .ext_val(ext_val), .ext_en(ext_en), .level(PAD_IN));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ready and read data are taken at the edge that samples them, before
  // the design updates; no wait-state count is assumed
  task automatic apb(input logic wr, input logic [31:0] idx,
                     input logic [31:0] wd);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx[29:0], 2'b00};
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(negedge CLOCK);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask

  function automatic logic [31:0] midx(input int p);
    return (p < 8) ? 32'h50003006 + 2 * p : 32'h50003026 + 2 * (p - 8);
  endfunction

  function automatic logic [31:0] mrst(input int p);
    return (p == 12 || p == 13) ? 32'h00000100 : 32'h00000200;
  endfunction

  task automatic wrap_up;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #(30000 * 100);
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(19181));
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    PORT0_LATCH <= 8'($urandom);
    for (int p = 0; p < 16; p++) begin
      apb(1'b0, midx(p), 32'h0);
      chk(rd, mrst(p));
    end
    chk(PAD_PULLDOWN_EN, 32'h0000CFFF);
    $display("test reset values done");
    for (int k = 0; k < 24; k++) begin
      d = $urandom;
      s = (k < 16) ? k : $urandom_range(15);
      apb(1'b1, midx(s), d);
      apb(1'b0, midx(s), 32'h0);
      chk(rd, d & 32'h0000031F);
    end
    for (int p = 0; p < 16; p++) apb(1'b1, midx(p), mrst(p));
    // lane 1 off: the pull code must keep its reset value
    @(posedge CLOCK);
    PSTRB <= 4'h1;
    apb(1'b1, midx(1), 32'h0000031F);
    @(posedge CLOCK);
    PSTRB <= 4'hF;
    apb(1'b0, midx(1), 32'h0);
    chk(rd, 32'h0000021F);
    apb(1'b1, midx(1), mrst(1));
    $display("test mode fields done");
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      s = (k == 0) ? 32'hFF : $urandom;
      c = (k == 0) ? 32'hFF : $urandom;
      apb(1'b1, 32'h50003020, d);
      chk(PORT1_LATCH, d[7:0]);
      apb(1'b1, 32'h50003022, s);
      chk(PORT1_LATCH, d[7:0] | s[7:0]);
      apb(1'b1, 32'h50003024, c);
      chk(PORT1_LATCH, (d[7:0] | s[7:0]) & ~c[7:0]);
      apb(1'b0, 32'h50003022, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 32'h50003024, 32'h0);
      chk(rd, 32'h0);
    end
    for (int p = 8; p < 16; p++) apb(1'b1, midx(p), 32'h300);
    apb(1'b1, 32'h50003020, 32'h5A);
    wt(2);
    apb(1'b0, 32'h50003020, 32'h0);
    chk(rd, 32'h5A);
    for (int p = 8; p < 16; p++) apb(1'b1, midx(p), 32'h000);
    d = $urandom;
    @(posedge CLOCK);
    ext_val <= {d[7:0] ^ 8'h5A, 8'h00};
    ext_en <= 16'hFF00;
    wt(3);
    apb(1'b0, 32'h50003020, 32'h0);
    chk(rd, {24'h0, d[7:0] ^ 8'h5A});
    $display("test port-1 data done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, midx(0), k << 8);
      wt(2);
      chk({PAD_PULLUP_EN[0], PAD_PULLDOWN_EN[0], PAD_OE[0]},
          {k == 1, k == 2, k == 3});
      chk(PAD_OE[0] & PAD_OUT[0], (k == 3) && PORT0_LATCH[0]);
    end
    for (int f = 1; f < 26; f++) begin
      @(posedge CLOCK);
      FUNC_OE <= 26'($urandom);
      FUNC_OUT <= 26'($urandom);
      apb(1'b1, midx(6), 32'h300 | f);
      wt(2);
      chk({PAD_OE[6], PAD_OE[6] & PAD_OUT[6], PAD_ANALOG_EN[6]},
          {f != 15 && FUNC_OE[f], f != 15 && FUNC_OE[f] && FUNC_OUT[f],
           1'b0});
    end
    apb(1'b1, midx(2), 32'h10F);
    apb(1'b1, midx(9), 32'h10F);
    wt(2);
    chk({PAD_ANALOG_EN[2], PAD_PULLUP_EN[2], PAD_OE[2]}, 3'b100);
    chk({PAD_ANALOG_EN[9], PAD_PULLUP_EN[9]}, 2'b01);
    @(posedge CLOCK);
    FUNC_OE <= 26'h3FFFFFF;
    apb(1'b1, midx(9), 32'h012);
    wt(2);
    chk(PAD_OE[9], 1'b0);
    $display("test pin functions done");
    @(posedge CLOCK);
    FUNC_OE <= 26'h0;
    for (int v = 0; v < 2; v++) begin
      @(posedge CLOCK);
      ext_en <= 16'h0208;
      ext_val <= v ? 16'h0008 : 16'h0200;
      apb(1'b1, midx(3), 32'h005);
      apb(1'b1, midx(9), 32'h005);
      wt(4);
      chk(FUNC_IN[5], v[0]);
      apb(1'b1, midx(3), 32'h000);
      wt(4);
      chk(FUNC_IN[5], v == 0);
    end
    apb(1'b0, 32'h00000400, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test priority and unmapped done");
    wrap_up();
  end
endmodule

`default_nettype wire
